// [inc/rpsel_pkg.sv]
// Purpose: constants for the remappable output pin select block
// Assumes: 32-bit axi4-lite register bus, registers one aligned word each
// Notes:   select codes index the peripheral source vector in list order
// Function
// - bits 13:8 of select register 0 choose the source for pin 35
// - bits 5:0 of select register 0 choose the source for pin 20
// - bits 13:8 of select register 1 choose the source for pin 37
// - bits 5:0 of select register 1 choose the source for pin 36
// - bits 15:14 and 7:6 read zero and ignore writes
// - all select fields reset to zero, the null mapping
// - each listed 6-bit code decodes to one peripheral output per fixed list; null and unlisted codes keep the port function
// - no lockout between fields; one source may drive several pins
package rpsel_pkg;
	localparam int          RPSEL_ADDR_W     = 4;
	localparam logic [3:0]  RPSEL_OFS_SEL0   = 4'h0;
	localparam logic [3:0]  RPSEL_OFS_SEL1   = 4'h4;
	localparam logic [15:0] RPSEL_SEL_RST    = 16'h0000;
	localparam logic [15:0] RPSEL_SEL_WMASK  = 16'h3f3f;
	localparam int          RPSEL_HI_LSB     = 8;
	localparam int          RPSEL_LO_LSB     = 0;
	localparam int          RPSEL_CODE_W     = 6;
	localparam int          RPSEL_NSRC       = 18;
	localparam logic [1:0]  RPSEL_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RPSEL_RESP_SLVERR = 2'h2;
	// peripheral source codes, index into the source vector in list order
	localparam logic [5:0] RPSEL_CODE_NULL   = 6'h00;
	localparam logic [5:0] RPSEL_CODES [RPSEL_NSRC] = '{
		6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11, 6'h12,
		6'h13, 6'h18, 6'h19, 6'h1a, 6'h2d, 6'h2f, 6'h31, 6'h32, 6'h00};
endpackage

// [src/rpsel_regs.sv]
// Purpose: axi4-lite slave holding the two output select registers
// Assumes: one write and one read at most in flight
// Notes:   unmapped addresses answer slverr, reads return zero
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rpsel_regs
	import rpsel_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [rpsel_pkg::RPSEL_ADDR_W-1:0] awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [rpsel_pkg::RPSEL_ADDR_W-1:0] araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic [15:0]                      sel0,
	output logic [15:0]                      sel1
);
	logic [RPSEL_ADDR_W-1:0] awaddr_ff;
	logic                    aw_ff, w_ff, bvalid_ff, rvalid_ff;
	logic                    awready_ff, wready_ff, arready_ff;
	logic [31:0]             wdata_ff, rdata_ff;
	logic [3:0]              wstrb_ff;
	logic [1:0]              bresp_ff, rresp_ff;
	logic [15:0]             sel0_ff, sel1_ff;
	wire                     do_wr  = aw_ff & w_ff & ~bvalid_ff;
	wire                     hit0   = (awaddr_ff == RPSEL_OFS_SEL0);
	wire                     hit1   = (awaddr_ff == RPSEL_OFS_SEL1);
	wire  [15:0]             bmask  = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}} & RPSEL_SEL_WMASK;
	// byte-enabled merge; the mask already keeps reserved bits clear
	function automatic logic [15:0] merge_sel(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		return (old & ~m) | (wd & m);
	endfunction
	wire  [15:0]             nxt_w0 = merge_sel(sel0_ff, wdata_ff[15:0], bmask);
	wire  [15:0]             nxt_w1 = merge_sel(sel1_ff, wdata_ff[15:0], bmask);
	// a channel is taken only while its registered ready stands
	wire                     aw_take    = awvalid & awready_ff;
	wire                     w_take     = wvalid & wready_ff;
	wire                     b_done     = bvalid_ff & bready;
	wire                     nxt_aw     = aw_take | (aw_ff & ~b_done);
	wire                     nxt_w      = w_take | (w_ff & ~b_done);
	wire                     rd_go      = arvalid & arready_ff;
	wire                     nxt_rvalid = rd_go | (rvalid_ff & ~rready);
	wire                     rhit0      = (araddr == RPSEL_OFS_SEL0);
	wire                     rhit1      = (araddr == RPSEL_OFS_SEL1);
	// readies are flops too, low in reset, so every port leaves a register
	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign arready = arready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	assign sel0    = sel0_ff;
	assign sel1    = sel1_ff;
	// capture address and data in either order, respond once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff      <= 1'b0;
			w_ff       <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RPSEL_RESP_OKAY;
			sel0_ff   <= RPSEL_SEL_RST;
			sel1_ff   <= RPSEL_SEL_RST;
		end else begin
			awready_ff <= ~nxt_aw;
			wready_ff  <= ~nxt_w;
			if (aw_take) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= awaddr;
			end
			if (w_take) begin
				w_ff     <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (hit0 | hit1) ? RPSEL_RESP_OKAY : RPSEL_RESP_SLVERR;
				if (hit0)
					sel0_ff <= nxt_w0;
				if (hit1)
					sel1_ff <= nxt_w1;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				aw_ff     <= 1'b0;
				w_ff      <= 1'b0;
			end
		end
	end
	// read path answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RPSEL_RESP_OKAY;
		end else begin
			rvalid_ff  <= nxt_rvalid;
			arready_ff <= ~nxt_rvalid;
			if (rd_go) begin
				rdata_ff <= {16'h0000, rhit0 ? sel0_ff : (rhit1 ? sel1_ff : 16'h0000)};
				rresp_ff <= (rhit0 | rhit1) ? RPSEL_RESP_OKAY : RPSEL_RESP_SLVERR;
			end
		end
	end
	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		((sel0_ff | sel1_ff) & ~RPSEL_SEL_WMASK) == 16'h0000)
		else $error("unimplemented select bits set");
	a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_wr && hit0 && wstrb_ff[0]) |=> (sel0_ff[5:0] == $past(wdata_ff[5:0])))
		else $error("select write did not land");
	a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go |=> rvalid_ff) else $error("read answer late");
endmodule
`default_nettype wire

// [src/rpsel_pin_mux.sv]
// Purpose: one remappable pin's source multiplexer
// Assumes: source vector ordered as the package code list
// Notes:   registered output, one cycle after select or source change
`timescale 1ns/1ps
`default_nettype none
module rpsel_pin_mux
	import rpsel_pkg::*;
(
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [rpsel_pkg::RPSEL_CODE_W-1:0] code,
	input  wire logic [rpsel_pkg::RPSEL_NSRC-2:0]   src,
	input  wire logic                              port_out,
	output logic                                   pin_out,
	output logic                                   remapped
);
	logic pin_out_ff, remapped_ff;
	logic hit;
	logic val;
	// decode to {remapped, level}; unmatched codes fall back to the port function
	function automatic logic [1:0] pick_src(input logic [RPSEL_CODE_W-1:0] c,
		input logic [RPSEL_NSRC-2:0] s, input logic p);
		logic [1:0] r;
		r = {1'b0, p};
		for (int i = 0; i < RPSEL_NSRC - 1; i++) begin
			if (c == RPSEL_CODES[i]) begin
				r = {1'b1, s[i]};
			end
		end
		return r;
	endfunction
	assign {hit, val} = pick_src(code, src, port_out);
	// one register stage so the pin never glitches through the decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_ff  <= 1'b0;
			remapped_ff <= 1'b0;
		end else begin
			pin_out_ff  <= val;
			remapped_ff <= hit;
		end
	end
	assign pin_out  = pin_out_ff;
	assign remapped = remapped_ff;
	// sampled reset in the antecedent: the release edge itself still clears the flops
	a_null_port: assert property (@(posedge aclk) disable iff (!aresetn)
		(aresetn && code == RPSEL_CODE_NULL) |=> (!remapped_ff && pin_out_ff == $past(port_out)))
		else $error("null code did not pick port");
	a_unlisted_null: assert property (@(posedge aclk) disable iff (!aresetn)
		(code == 6'h02) |=> !remapped_ff) else $error("unlisted code remapped");
	a_serial1_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(code == 6'h01) |=> (remapped_ff && pin_out_ff == $past(src[0])))
		else $error("code 1 wrong source");
endmodule
`default_nettype wire

// [src/rpsel_top.sv]
// Purpose: remappable output pin select, four pins, axi4-lite registers
// Assumes: peripheral outputs and port latches are on aclk
// Notes:   pin outputs lag a register write by one cycle
`timescale 1ns/1ps
`default_nettype none
module rpsel_top
	import rpsel_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [rpsel_pkg::RPSEL_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [rpsel_pkg::RPSEL_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [rpsel_pkg::RPSEL_NSRC-2:0] periph_out,
	input  wire logic [3:0]                  port_out,
	output logic [3:0]                       pin_out,
	output logic [3:0]                       pin_remapped
);
	logic [15:0] sel0, sel1;
	logic [5:0]  code [4];
	// field split: pins 20, 35, 36, 37; no cross-field lockout
	assign code[0] = sel0[RPSEL_LO_LSB +: RPSEL_CODE_W];
	assign code[1] = sel0[RPSEL_HI_LSB +: RPSEL_CODE_W];
	assign code[2] = sel1[RPSEL_LO_LSB +: RPSEL_CODE_W];
	assign code[3] = sel1[RPSEL_HI_LSB +: RPSEL_CODE_W];
	rpsel_regs u_regs (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.sel0    (sel0),
		.sel1    (sel1)
	);
	// every pin sees the full source set, so one source may feed many pins
	for (genvar p = 0; p < 4; p++) begin : g_pin
		rpsel_pin_mux u_mux (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.code     (code[p]),
			.src      (periph_out),
			.port_out (port_out[p]),
			.pin_out  (pin_out[p]),
			.remapped (pin_remapped[p])
		);
	end
	a_same_src: assert property (@(posedge aclk) disable iff (!aresetn)
		(code[0] == code[3] && code[0] == 6'h01) |=> (pin_out[0] == pin_out[3]))
		else $error("shared source differs");
	a_pin35_field: assert property (@(posedge aclk) disable iff (!aresetn)
		(code[1] != 6'h00 && code[1] == 6'h03) |=> pin_remapped[1])
		else $error("pin 35 field not decoded");
endmodule
`default_nettype wire

// [verif/rpsel_src_model.sv]
// Purpose: model of the peripheral outputs and port latches feeding the pins
// Assumes: every source changes on aclk
// Notes:   an lfsr keeps each source toggling, so a stale or wrong pick shows
`timescale 1ns/1ps
`default_nettype none
module rpsel_src_model (
	input  wire logic        aclk,
	output logic [16:0]      periph_out,
	output logic [3:0]       port_out
);
	logic [20:0] lfsr_ff = 21'h1b5e3;
	// free-running shift pattern, each source takes its lower neighbour's last value
	always_ff @(posedge aclk) begin
		lfsr_ff <= {lfsr_ff[19:0], lfsr_ff[20] ^ lfsr_ff[18]};
	end
	assign periph_out = lfsr_ff[16:0];
	assign port_out   = lfsr_ff[20:17];
endmodule
`default_nettype wire

// [verif/test_remappable_output_pin_select.sv]
// Purpose: self-checking bench for the remappable output pin select
// Assumes: bus signals change just after the rising edge
// Notes:   handshakes are read at the falling edge, where they have settled
`timescale 1ns/1ps
`default_nettype none
module test_remappable_output_pin_select;
	import rpsel_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	logic [16:0] periph_out, p_src;
	logic [3:0]  port_out, p_port, pin_out, pin_remapped;
	logic [5:0]  cd [4];
	int          bad_count = 0, num_checks = 0;

	rpsel_src_model rpsel_src_model_inst (.aclk(aclk), .periph_out(periph_out), .port_out(port_out));
	rpsel_top rpsel_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_out(periph_out),
		.port_out(port_out), .pin_out(pin_out), .pin_remapped(pin_remapped));

	// 8 ns clock; sources as the design saw them at the last edge
	initial forever #4 aclk = ~aclk;
	always @(posedge aclk) begin
		p_src <= periph_out;
		p_port <= port_out;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		{awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'h7};
		do begin
			@(negedge aclk);
			ta = awready & awvalid;
			tw = wready & wvalid;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		logic [33:0] r;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do begin
			@(negedge aclk);
			ta = arready & arvalid;
			tr = rvalid;
			r = {rresp, rdata};
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
		chk(r[31:0], ed);
		chk({30'h0, r[33:32]}, {30'h0, er});
	endtask

	// expected {remapped, level} of one pin; unlisted codes fall back to the port
	function automatic logic [1:0] ex(input logic [5:0] c, input logic [16:0] s, input logic p);
		for (int i = 0; i < 17; i++) if (RPSEL_CODES[i] == c) return {1'b1, s[i]};
		return {1'b0, p};
	endfunction

	task automatic pins(input int k);
		logic [1:0] e [4];
		repeat (k) begin
			@(negedge aclk);
			for (int i = 0; i < 4; i++) e[i] = ex(cd[i], p_src, p_port[i]);
			chk({24'h0, pin_remapped, pin_out}, {24'h0, e[3][1], e[2][1], e[1][1], e[0][1],
				e[3][0], e[2][0], e[1][0], e[0][0]});
		end
	endtask

	// codes in pin order 20, 35, 36, 37
	task automatic setc(input logic [5:0] c0, c1, c2, c3);
		cd = '{c0, c1, c2, c3};
		wr(4'h0, {18'h0, c1, 2'h0, c0}, 4'hf, RPSEL_RESP_OKAY);
		wr(4'h4, {18'h0, c3, 2'h0, c2}, 4'hf, RPSEL_RESP_OKAY);
		rd(4'h4, {18'h0, c3, 2'h0, c2}, RPSEL_RESP_OKAY);
		pins(4);
	endtask

	task automatic t_reset();
		cd = '{6'h0, 6'h0, 6'h0, 6'h0};
		rd(4'h0, 32'h0, RPSEL_RESP_OKAY);
		rd(4'h4, 32'h0, RPSEL_RESP_OKAY);
		pins(4);
	endtask

	task automatic t_codes();
		for (int i = 0; i < 18; i++) setc(RPSEL_CODES[i], RPSEL_CODES[i], RPSEL_CODES[i], RPSEL_CODES[i]);
		setc(6'h02, 6'h3f, 6'h04, 6'h33);
	endtask

	task automatic t_reserved();
		wr(4'h0, 32'hffffffff, 4'hf, RPSEL_RESP_OKAY);
		rd(4'h0, 32'h3f3f, RPSEL_RESP_OKAY);
		wr(4'h4, 32'hc0c0c0c0, 4'hf, RPSEL_RESP_OKAY);
		rd(4'h4, 32'h0, RPSEL_RESP_OKAY);
		wr(4'h0, 32'h0101, 4'h1, RPSEL_RESP_OKAY);
		rd(4'h0, 32'h3f01, RPSEL_RESP_OKAY);
	endtask

	task automatic t_unmapped();
		wr(4'h8, 32'h0101, 4'hf, RPSEL_RESP_SLVERR);
		rd(4'h8, 32'h0, RPSEL_RESP_SLVERR);
		rd(4'h0, 32'h3f01, RPSEL_RESP_OKAY);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		setc(6'h01, 6'h03, 6'h08, 6'h32);
		t_codes();
		t_reserved();
		t_unmapped();
		print_verdict();
	end

	// hang guard: bus tasks wait without limit, the run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
